// [dv/spr_core_model.sv]
// core pipeline model that issues coprocessor moves to the group
`timescale 1ns/1ps
module spr_core_model (
    clk,
    cop_valid,
    cop_write,
    cop_num,
    cop_crn,
    cop_crm,
    cop_op2,
    cop_wdata,
    cop_priv
);
    input  wire logic        clk;
    output logic             cop_valid;
    output logic             cop_write;
    output logic      [3:0]  cop_num;
    output logic      [3:0]  cop_crn;
    output logic      [3:0]  cop_crm;
    output logic      [2:0]  cop_op2;
    output logic      [31:0] cop_wdata;
    output logic             cop_priv;
    initial begin
        {cop_valid, cop_write, cop_num, cop_crn, cop_crm, cop_op2, cop_wdata, cop_priv} = '0;
    end
    // entered just after a falling edge, one move per cycle, then two idle cycles after a write to register 15 of coprocessor 15
    task automatic move(input logic w, input logic [3:0] n, c, m, input logic [31:0] d, input logic p);
        {cop_valid, cop_write, cop_num, cop_crn, cop_crm, cop_wdata, cop_priv} = {1'b1, w, n, c, m, d, p};
        @(negedge clk);
        if (w && n == 4'hf && c == 4'hf) begin
            cop_valid = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask
    // idle write, register and data lines do not keep the last value, so stale data cannot pass for a move
    task automatic idle(input logic [1:0] k);
        cop_valid = 1'b0;
        {cop_write, cop_crn, cop_wdata} = ~{cop_write, cop_crn, cop_wdata};
        repeat (k) @(negedge clk);
    endtask
endmodule // spr_core_model

// [dv/sysctl_pid_remap_and_cop_access_tb_top.sv]
// self-checking bench: corner and random coprocessor moves against a shadow of the group
`timescale 1ns/1ps
module sysctl_pid_remap_and_cop_access_tb_top;
    import spr_pkg::*;
    logic        clk, resetn, cop_valid, cop_write, cop_priv, cop_undef, btb_invalidate;
    logic [3:0]  cop_num, cop_crn, cop_crm;
    logic [2:0]  cop_op2;
    logic [31:0] cop_wdata, cop_rdata, fetch_vaddr, data_vaddr, fetch_mva, data_mva, btb_lookup_addr;
    logic [31:0] instr_breakpoint_reg_a, instr_breakpoint_reg_b, data_breakpoint_addr;
    logic [31:0] data_mask_or_addr, data_breakpoint_control, coprocessor_access_mask;
    logic [31:0] sh_slot, sh_mask, vr;
    logic [31:0] sh_bk [5];
    logic [3:0]  crms [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h8, 4'h9};
    integer      seed = 32'h65a3_3eda, fail_count = 0, comparisons = 0, cycles = 0, i, j;

    spr_sysctl dut (.clk, .resetn, .cop_valid, .cop_write, .cop_num, .cop_crn, .cop_crm, .cop_op2,
        .cop_wdata, .cop_priv, .cop_rdata, .cop_undef, .fetch_vaddr, .data_vaddr, .fetch_mva, .data_mva,
        .btb_lookup_addr, .btb_invalidate, .instr_breakpoint_reg_a, .instr_breakpoint_reg_b,
        .data_breakpoint_addr, .data_mask_or_addr, .data_breakpoint_control, .coprocessor_access_mask);
    spr_core_model core (.clk, .cop_valid, .cop_write, .cop_num, .cop_crn, .cop_crm, .cop_op2,
        .cop_wdata, .cop_priv);

    function automatic logic [31:0] exp_mva(input logic [31:0] v);
        exp_mva = (v[31:25] == 7'h00) ? (v | sh_slot) : v;
    endfunction
    function automatic int bsel(input logic [3:0] m);
        bsel = m == 4'h8 ? 0 : m == 4'h9 ? 1 : m == 4'h0 ? 2 : m == 4'h3 ? 3 : m == 4'h4 ? 4 : 7;
    endfunction
    function automatic logic [31:0] exp_rd(input logic [3:0] c, m);
        exp_rd = 32'h0000_0000;
        if (c == CRN_SLOT && m == CRM_SLOT) exp_rd = sh_slot;
        if (c == CRN_ACCESS && m == CRM_ACCESS) exp_rd = sh_mask;
        if (c == CRN_BKPT && bsel(m) < 5) exp_rd = sh_bk[bsel(m)];
    endfunction
    task automatic check(input logic [287:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic op(input logic w, input logic [3:0] n, c, m, input logic [31:0] d, input logic p);
        logic ok, u;
        ok = p || (n < CP_DEBUG && sh_mask[n]);
        vr = $random(seed);
        fetch_vaddr = vr[0] ? vr & 32'h01ff_ffff : vr;
        data_vaddr = vr[1] ? ~vr & 32'h01ff_ffff : ~vr;
        fork
            core.move(w, n, c, m, d, p);
            begin #1 u = cop_undef; end
        join
        check(u, !ok);
        ok = ok && n == CP_SYSCTL;
        check(btb_invalidate, ok && w && c == CRN_SLOT && m == CRM_SLOT);
        if (ok && !w) check(cop_rdata, exp_rd(c, m));
        if (ok && w && c == CRN_SLOT && m == CRM_SLOT) sh_slot = d & 32'hfe00_0000;
        if (ok && w && c == CRN_ACCESS && m == CRM_ACCESS) sh_mask = d & 32'h0000_3fff;
        if (ok && w && c == CRN_BKPT && bsel(m) < 5) sh_bk[bsel(m)] = d;
        check({instr_breakpoint_reg_a, instr_breakpoint_reg_b, data_breakpoint_addr, data_mask_or_addr,
            data_breakpoint_control, coprocessor_access_mask, fetch_mva, data_mva, btb_lookup_addr},
            {sh_bk[0], sh_bk[1], sh_bk[2], sh_bk[3], sh_bk[4], sh_mask, exp_mva(fetch_vaddr),
            exp_mva(data_vaddr), fetch_vaddr});
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        resetn = 1'b0;
        fetch_vaddr = 32'h0000_0000;
        data_vaddr = 32'h0000_0000;
        sh_slot = 32'h0000_0000;
        sh_mask = 32'h0000_0000;
        sh_bk = '{default: 32'h0000_0000};
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        // reset values, back to back
        for (i = 0; i < 30; i++) op(1'b0, CP_SYSCTL, 4'(CRN_RSVD_A + i / 6), crms[i % 6], '0, 1'b1);
        // trapped request, grant, retry
        op(1'b0, 4'h5, 4'h0, 4'h0, 32'h0000_0000, 1'b0);
        op(1'b1, CP_SYSCTL, CRN_ACCESS, CRM_ACCESS, 32'hffff_c020, 1'b1);
        op(1'b0, 4'h5, 4'h0, 4'h0, 32'h0000_0000, 1'b0);
        op(1'b1, CP_SYSCTL, CRN_SLOT, CRM_SLOT, 32'hffff_ffff, 1'b0);
        op(1'b1, CP_SYSCTL, CRN_SLOT, CRM_SLOT, 32'hffff_ffff, 1'b1);
        op(1'b1, CP_SYSCTL, CRN_RSVD_B, CRM_SLOT, 32'h1234_5678, 1'b1);
        op(1'b0, CP_SYSCTL, CRN_RSVD_B, CRM_SLOT, 32'h0000_0000, 1'b1);
        for (i = 0; i < 400; i++) begin
            vr = $random(seed);
            j = vr[3:1] == 3'h0 ? vr[7:4] : CP_SYSCTL;
            op(vr[8], 4'(j), j == CP_SYSCTL ? 4'(CRN_RSVD_A + vr[11:9] % 5) : 4'h0, crms[vr[14:12] % 6],
                vr[15] ? exp_mva(vr & 32'h01ff_ffc0) : $random(seed), vr[16] | vr[17]);
            if (vr[19:18] != 2'h0) core.idle(vr[19:18]);
        end
        core.idle(2'h1);
        give_verdict();
    end
endmodule // sysctl_pid_remap_and_cop_access_tb_top

// [hdl/spr_pkg.sv]
// package: constants for the process slot remap and coprocessor access group
package spr_pkg;
    localparam logic [3:0]  CRN_RSVD_A      = 4'h0b;
    localparam logic [3:0]  CRN_RSVD_B      = 4'h0c;
    localparam logic [3:0]  CRN_SLOT        = 4'h0d;
    localparam logic [3:0]  CRN_BKPT        = 4'h0e;
    localparam logic [3:0]  CRN_ACCESS      = 4'h0f;
    localparam logic [2:0]  OP2_ZERO        = 3'h0;
    localparam logic [3:0]  CRM_SLOT        = 4'h0;
    localparam logic [3:0]  CRM_IBRK_A      = 4'h8;
    localparam logic [3:0]  CRM_IBRK_B      = 4'h9;
    localparam logic [3:0]  CRM_DBRK_ADDR   = 4'h0;
    localparam logic [3:0]  CRM_DBRK_MASK   = 4'h3;
    localparam logic [3:0]  CRM_DBRK_CTRL   = 4'h4;
    localparam logic [3:0]  CRM_ACCESS      = 4'h1;
    localparam logic [3:0]  CP_DEBUG        = 4'he;
    localparam logic [3:0]  CP_SYSCTL       = 4'hf;
    localparam int          SLOT_LSB        = 25;
    localparam int          SLOT_W          = 7;
    localparam int          MASK_W          = 14;
    localparam logic [31:0] SLOT_RESET      = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
    localparam logic [31:0] BKPT_RESET      = 32'h0000_0000;
    typedef enum logic [2:0] {
        SPR_BK_IA, SPR_BK_IB, SPR_BK_DA, SPR_BK_DM, SPR_BK_DC
    } spr_bkpt_sel_t;
endpackage

// [hdl/spr_remap.sv]
// module: process slot remap of one virtual address path
`timescale 1ns/1ps
module spr_remap (
    virt_addr,
    slot_id,
    remapped_addr
);
    import spr_pkg::*;
    input  wire logic [31:0]       virt_addr;
    input  wire logic [SLOT_W-1:0] slot_id;
    output logic      [31:0]       remapped_addr;

    logic top_zero;
    assign top_zero = (virt_addr[31:SLOT_LSB] == '0);
    // or-in only when the top field is clear, else pass untouched
    assign remapped_addr = top_zero ? {slot_id, virt_addr[SLOT_LSB-1:0]} : virt_addr;
endmodule // spr_remap

// [hdl/spr_sysctl.sv]
// module: system-control registers 11..15: slot remap, breakpoint decode, access mask
//
// What this block does
// - registers 11 and 12 reserved; reads give zero, writes do nothing.
// - slot remap applied before instruction/data cache and TLB lookups.
// - top seven address bits all zero: or in the slot identifier.
// - any top bit set: address passes through unchanged.
// - slot register bits 31:25 hold the identifier, read/write, used for remap.
// - slot register bits 24:0 read zero, writes ignored.
// - slot register reached by register 13, opcode2 0, minor field 0.
// - branch target buffer lookups use the unremapped address.
// - every slot register write invalidates the whole branch target buffer.
// - register 14 minor field selects the five breakpoint registers.
// - access mask is register 15, opcode2 0, minor field 1.
// - mask covers all but coprocessors 14,15; those need privileged mode.
// - user access to a masked-off coprocessor raises undefined instruction.
// - mask bits 13:0 read/write; 0 denies, 1 permits.
// - mask bits 31:14 reserved write-ignored; register resets to zero.
`timescale 1ns/1ps
module spr_sysctl (
    clk,
    resetn,
    cop_valid,
    cop_write,
    cop_num,
    cop_crn,
    cop_crm,
    cop_op2,
    cop_wdata,
    cop_priv,
    cop_rdata,
    cop_undef,
    fetch_vaddr,
    data_vaddr,
    fetch_mva,
    data_mva,
    btb_lookup_addr,
    btb_invalidate,
    instr_breakpoint_reg_a,
    instr_breakpoint_reg_b,
    data_breakpoint_addr,
    data_mask_or_addr,
    data_breakpoint_control,
    coprocessor_access_mask
);
    import spr_pkg::*;
    input  wire logic        clk;
    input  wire logic        resetn;
    input  wire logic        cop_valid;
    input  wire logic        cop_write;
    input  wire logic [3:0]  cop_num;
    input  wire logic [3:0]  cop_crn;
    input  wire logic [3:0]  cop_crm;
    input  wire logic [2:0]  cop_op2;
    input  wire logic [31:0] cop_wdata;
    input  wire logic        cop_priv;
    output logic      [31:0] cop_rdata;
    output logic             cop_undef;
    input  wire logic [31:0] fetch_vaddr;
    input  wire logic [31:0] data_vaddr;
    output logic      [31:0] fetch_mva;
    output logic      [31:0] data_mva;
    output logic      [31:0] btb_lookup_addr;
    output logic             btb_invalidate;
    output logic      [31:0] instr_breakpoint_reg_a;
    output logic      [31:0] instr_breakpoint_reg_b;
    output logic      [31:0] data_breakpoint_addr;
    output logic      [31:0] data_mask_or_addr;
    output logic      [31:0] data_breakpoint_control;
    output logic      [31:0] coprocessor_access_mask;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // access decode and permission
    // ------------------------------------------------------------
    function automatic logic sel(input logic [3:0] crn, input logic [3:0] minor_register_field);
        sel = (cop_num == CP_SYSCTL) && (cop_crn == crn) && (cop_crm == minor_register_field) && (cop_op2 == OP2_ZERO);
    endfunction

    logic [SLOT_W-1:0] slot_q;
    logic [MASK_W-1:0] mask_q;
    logic [31:0]       bkpt_q [5];
    logic              is_sys, allowed, take, wr;

    assign is_sys = (cop_num == CP_SYSCTL) || (cop_num == CP_DEBUG);
    // system coprocessors need privilege; others need privilege or their mask bit set
    always_comb begin
        if (is_sys) begin
            allowed = cop_priv;
        end else if (cop_num < 4'(MASK_W)) begin
            allowed = cop_priv || mask_q[cop_num];
        end else begin
            allowed = cop_priv;
        end
    end
    assign cop_undef = cop_valid && !allowed;
    assign take      = cop_valid && allowed;
    assign wr        = take && cop_write;

    // ------------------------------------------------------------
    // process slot register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            slot_q <= SLOT_RESET[31:SLOT_LSB];
        end else if (wr && sel(CRN_SLOT, CRM_SLOT)) begin
            slot_q <= cop_wdata[31:SLOT_LSB];
        end
    end

    // whole buffer flushed so no prediction crosses processes
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            btb_invalidate <= 1'b0;
        end else begin
            btb_invalidate <= wr && sel(CRN_SLOT, CRM_SLOT);
        end
    end

    // ------------------------------------------------------------
    // breakpoint registers
    // ------------------------------------------------------------
    localparam logic [3:0] BK_CRM [5] = '{CRM_IBRK_A, CRM_IBRK_B, CRM_DBRK_ADDR, CRM_DBRK_MASK, CRM_DBRK_CTRL};
    for (genvar i = 0; i < 5; i++) begin : g_bk
        always_ff @(posedge clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                bkpt_q[i] <= BKPT_RESET;
            end else if (wr && sel(CRN_BKPT, BK_CRM[i])) begin
                bkpt_q[i] <= cop_wdata;
            end
        end
    end
    assign instr_breakpoint_reg_a  = bkpt_q[SPR_BK_IA];
    assign instr_breakpoint_reg_b  = bkpt_q[SPR_BK_IB];
    assign data_breakpoint_addr    = bkpt_q[SPR_BK_DA];
    assign data_mask_or_addr       = bkpt_q[SPR_BK_DM];
    assign data_breakpoint_control = bkpt_q[SPR_BK_DC];

    // ------------------------------------------------------------
    // coprocessor access mask
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_q <= MASK_RESET[MASK_W-1:0];
        end else if (wr && sel(CRN_ACCESS, CRM_ACCESS)) begin
            mask_q <= cop_wdata[MASK_W-1:0];
        end
    end
    assign coprocessor_access_mask = {{(32-MASK_W){1'b0}}, mask_q};

    // ------------------------------------------------------------
    // read data, registered one cycle after the move
    // ------------------------------------------------------------
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h0000_0000; // reserved 11, 12 and unmapped read zero
        if (sel(CRN_SLOT, CRM_SLOT)) begin
            rd_d = {slot_q, 25'h000_0000};
        end else if (sel(CRN_ACCESS, CRM_ACCESS)) begin
            rd_d = coprocessor_access_mask;
        end else begin
            for (int j = 0; j < 5; j++) begin
                if (sel(CRN_BKPT, BK_CRM[j])) begin
                    rd_d = bkpt_q[j];
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cop_rdata <= 32'h0000_0000;
        end else if (take && !cop_write) begin
            cop_rdata <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // address paths
    // ------------------------------------------------------------
    spr_remap u_fetch (.virt_addr(fetch_vaddr), .slot_id(slot_q), .remapped_addr(fetch_mva));
    spr_remap u_data  (.virt_addr(data_vaddr),  .slot_id(slot_q), .remapped_addr(data_mva));
    assign btb_lookup_addr = fetch_vaddr;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    remap_zero_a: assert property ((fetch_vaddr[31:25] == 7'h00) |-> fetch_mva[31:25] == slot_q)
        else $error("remap not applied");
    remap_pass_a: assert property ((data_vaddr[31:25] != 7'h00) |-> data_mva == data_vaddr)
        else $error("remap altered address");
    remap_low_a: assert property (fetch_mva[24:0] == fetch_vaddr[24:0])
        else $error("low bits changed");
    slot_write_a: assert property (wr && sel(CRN_SLOT, CRM_SLOT) |=> slot_q == $past(cop_wdata[31:25]))
        else $error("slot not written");
    btb_flush_a: assert property (wr && sel(CRN_SLOT, CRM_SLOT) |=> btb_invalidate)
        else $error("no buffer flush");
    btb_raw_a: assert property (btb_lookup_addr == fetch_vaddr)
        else $error("buffer path remapped");
    slot_rd_a: assert property (take && !cop_write && sel(CRN_SLOT, CRM_SLOT) |=> cop_rdata[24:0] == 25'h0)
        else $error("reserved slot bits set");
    undef_a: assert property (cop_valid && !cop_priv && !is_sys && cop_num < 4'(MASK_W) && !mask_q[cop_num]
        |-> cop_undef)
        else $error("denied access not trapped");
    sys_priv_a: assert property (cop_valid && is_sys && !cop_priv |-> cop_undef)
        else $error("user reached system coprocessor");
    mask_hi_a: assert property (coprocessor_access_mask[31:14] == 18'h0)
        else $error("reserved mask bits set");
    mask_wr_a: assert property (wr && sel(CRN_ACCESS, CRM_ACCESS) |=> mask_q == $past(cop_wdata[13:0]))
        else $error("mask not written");

    slot_wr_c: cover property (wr && sel(CRN_SLOT, CRM_SLOT));
    undef_c:   cover property (cop_undef);
    mask_wr_c: cover property (wr && sel(CRN_ACCESS, CRM_ACCESS));
    bk_wr_c:   cover property (wr && sel(CRN_BKPT, CRM_DBRK_CTRL));
endmodule // spr_sysctl
